// [inc/meas_params.svh]
`ifndef MEAS_PARAMS_SVH
`define MEAS_PARAMS_SVH

// Clock and time base
`define CLK_HZ      20000000
`define US_CYC      (`CLK_HZ / 1000000)
`define CHOP_US     100
`define CHOP_CYC    (`CHOP_US * `US_CYC)
`define FAST_WINS   18'd1

// Register byte offsets
`define A_CTRL      12'h000
`define A_INTEGRATION_WINDOW_TIME      12'h004
`define A_AVG       12'h008
`define A_GRACE     12'h00c
`define A_SLEN      12'h010
`define A_SQTY      12'h014
`define A_DEPTH     12'h018
`define A_LEVEL     12'h01c
`define A_CMD       12'h020
`define A_STAT      12'h024
`define A_FILL      12'h028
`define A_RES       12'h02c
`define A_STORE     12'h030
`define A_PLEN      12'h034
`define A_SLOTS_HI  3'b001

// Field positions
`define F_MODE      1:0
`define F_SMOOTH    2
`define F_FAST      3
`define F_BUF       4
`define F_SRC       6:5
`define F_FLUSH     0
`define F_SWTRIG    1

// Ranges and reset values
`define INTEGRATION_WINDOW_TIME_MIN    22'd8
`define INTEGRATION_WINDOW_TIME_MAX    22'd2000000
`define INTEGRATION_WINDOW_TIME_RST    22'd20000
`define AVG_MIN     17'd1
`define AVG_MAX     17'd65536
`define AVG_RST     17'd4
`define GRACE_MIN   19'd0
`define GRACE_MAX   19'd300000
`define GRACE_RST   19'd1
`define SLEN_MIN    17'd10
`define SLEN_MAX    17'd100000
`define SLEN_RST    17'd1000
`define QTY_MIN     8'd1
`define QTY_MAX     8'd128
`define QTY_RST     8'd8
`define DEPTH_MIN   14'd1
`define DEPTH_MAX   14'd8192
`define DEPTH_RST   14'd1
`define LEVEL_RST   16'h0100
`define STORE_N     8192
`define SLOT_N      128

`endif

// [inc/meas_pkg.sv]
package meas_pkg;

  typedef enum logic [1:0] {
    MODE_CONT  = 2'b00,
    MODE_BURST = 2'b01,
    MODE_SLOT  = 2'b10,
    MODE_OFF   = 2'b11
  } meas_mode_t;

  typedef enum logic [1:0] {
    SRC_IMM  = 2'b00,
    SRC_LVL  = 2'b01,
    SRC_EXT  = 2'b10,
    SRC_HOLD = 2'b11
  } trig_src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WIN   = 3'b001,
    ST_GAP   = 3'b010,
    ST_BURST = 3'b011,
    ST_GRACE = 3'b100,
    ST_SLOT  = 3'b101
  } eng_state_t;

  typedef struct packed {
    meas_mode_t  mode;
    logic        smooth;
    logic        fast;
    logic        buf_en;
    trig_src_t   src;
    logic [21:0] integration_window_time;
    logic [16:0] avg;
    logic [18:0] grace;
    logic [16:0] slen;
    logic [7:0]  qty;
    logic [13:0] depth;
    logic [15:0] level;
  } cfg_t;

  typedef struct packed {
    logic       slot;
    logic [6:0] idx;
  } dv_tag_t;

endpackage

// [src/power_meter.sv]
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "meas_params.svh"
// What this block does
// - Smoothing filter switchable, off after reset
// - Smoothing weights continuous-mode window samples with raised Hann
// - No smoothing: equal weights, plain average
// - Chopped time: 2*count windows plus switch gaps
// - Fast mode: no chopper, one window
// - Fast mode windows run back to back
// - Fast mode selectable, off after reset
// - Flush empties result store, fill zero
// - Fill count readable by host
// - Store depth 1 to 8192, default 1
// - Buffer enabled stores results until full
// - Burst starts above level, ends below
// - Burst ends after whole grace time below
// - Burst uses only signal level trigger
// - Burst ignores delay, starts at crossing
// - Pulse length from trigger to end detection
// - Timeslot mode: one result per slot
// - Timeslots follow selected trigger source
// - Slot quantity 1 to 128, default 8
// - Window 8 us to 2 s, default 20 ms
// - Slot length 10 us to 100 ms, default 1 ms
module power_meter
  import meas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        trig_pin,
  output logic             chop_phase,
  output logic             meas_busy
);
  cfg_t        cfg_q;
  eng_state_t  st_q;
  dv_tag_t     dv_tag_q;
  logic [11:0] ap_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [31:0] rdata;
  logic [2:0]  tp_q;
  logic        above_q;
  logic [4:0]  tus_q;
  logic [21:0] pos_q;
  logic [17:0] win_q;
  logic [7:0]  sidx_q;
  logic [18:0] gr_q;
  logic [31:0] plen_q;
  logic [31:0] pulse_len_q;
  logic [55:0] acc_q;
  logic [39:0] ws_q;
  logic [4:0]  sh_q;
  logic        dv_go_q;
  logic [55:0] dv_num_q;
  logic [39:0] dv_den_q;
  logic        dv_done;
  logic [31:0] dv_quo;
  logic [31:0] result_q;
  logic        res_vld_q;
  logic        slot_vld_q;
  logic [31:0] slot_res_q [`SLOT_N];
  logic [31:0] store_q [`STORE_N];
  logic [12:0] wp_q;
  logic [12:0] rp_q;
  logic [13:0] fill_q;
  logic [11:0] gap_cyc_q;
  logic        take;
  logic        flush;
  logic        sw_trig;
  logic        above_now;
  logic        lvl_rise;
  logic        ext_rise;
  logic        trig_ev;
  logic        us_tick;
  logic        acc_en;
  logic        use_hann;
  logic        abort;
  logic        res_done;
  logic        push;
  logic        pop;
  logic        win_last;
  logic        pos_end;
  logic [17:0] win_need;
  logic [16:0] w;
  logic [16:0] w_hann;
  logic [55:0] acc_add;
  logic [39:0] ws_add;

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [4:0] win_shift(input logic [21:0] len);
    logic [4:0] s;
    s = 5'd0;
    for (int i = 8; i < 22; i++)
      if (len[i])
        s = 5'(i - 7);
    return s;
  endfunction

  // Bus slave: zero wait writes, one wait reads so a read sees a write just before it
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ap_q      <= '0;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take)
        ap_q <= haddr[11:0];
      if (take && !hwrite)
        hreadyout <= 1'b0;
      else if (rd_pend_q)
      begin
        hreadyout <= 1'b1;
        hrdata    <= rdata;
      end
    end
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (ap_q)
      `A_CTRL:  rdata = {25'd0, cfg_q.src, cfg_q.buf_en, cfg_q.fast, cfg_q.smooth, cfg_q.mode};
      `A_INTEGRATION_WINDOW_TIME:  rdata = {10'd0, cfg_q.integration_window_time};
      `A_AVG:   rdata = {15'd0, cfg_q.avg};
      `A_GRACE: rdata = {13'd0, cfg_q.grace};
      `A_SLEN:  rdata = {15'd0, cfg_q.slen};
      `A_SQTY:  rdata = {24'd0, cfg_q.qty};
      `A_DEPTH: rdata = {18'd0, cfg_q.depth};
      `A_LEVEL: rdata = {16'd0, cfg_q.level};
      `A_STAT:  rdata = {25'd0, st_q, chop_phase, meas_busy, slot_vld_q, res_vld_q};
      `A_FILL:  rdata = {18'd0, fill_q};
      `A_RES:   rdata = result_q;
      `A_STORE: rdata = (fill_q != 14'd0) ? store_q[rp_q] : 32'h0000_0000;
      `A_PLEN:  rdata = pulse_len_q;
      default:
        if (ap_q[11:9] == `A_SLOTS_HI)
          rdata = slot_res_q[ap_q[8:2]];
    endcase
  end

  // Configuration; out-of-range writes are clamped to the legal span
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q.mode   <= MODE_CONT;
      cfg_q.smooth <= 1'b0;
      cfg_q.fast   <= 1'b0;
      cfg_q.buf_en <= 1'b0;
      cfg_q.src    <= SRC_IMM;
      cfg_q.integration_window_time   <= `INTEGRATION_WINDOW_TIME_RST;
      cfg_q.avg    <= `AVG_RST;
      cfg_q.grace  <= `GRACE_RST;
      cfg_q.slen   <= `SLEN_RST;
      cfg_q.qty    <= `QTY_RST;
      cfg_q.depth  <= `DEPTH_RST;
      cfg_q.level  <= `LEVEL_RST;
    end
    else if (wr_pend_q)
    begin
      case (ap_q)
        `A_CTRL:
        begin
          cfg_q.mode   <= meas_mode_t'(hwdata[`F_MODE]);
          cfg_q.smooth <= hwdata[`F_SMOOTH];
          cfg_q.fast   <= hwdata[`F_FAST];
          cfg_q.buf_en <= hwdata[`F_BUF];
          cfg_q.src    <= trig_src_t'(hwdata[`F_SRC]);
        end
        `A_INTEGRATION_WINDOW_TIME:  cfg_q.integration_window_time  <= 22'(clamp(hwdata, 32'(`INTEGRATION_WINDOW_TIME_MIN), 32'(`INTEGRATION_WINDOW_TIME_MAX)));
        `A_AVG:   cfg_q.avg   <= 17'(clamp(hwdata, 32'(`AVG_MIN), 32'(`AVG_MAX)));
        `A_GRACE: cfg_q.grace <= 19'(clamp(hwdata, 32'(`GRACE_MIN), 32'(`GRACE_MAX)));
        `A_SLEN:  cfg_q.slen  <= 17'(clamp(hwdata, 32'(`SLEN_MIN), 32'(`SLEN_MAX)));
        `A_SQTY:  cfg_q.qty   <= 8'(clamp(hwdata, 32'(`QTY_MIN), 32'(`QTY_MAX)));
        `A_DEPTH: cfg_q.depth <= 14'(clamp(hwdata, 32'(`DEPTH_MIN), 32'(`DEPTH_MAX)));
        `A_LEVEL: cfg_q.level <= hwdata[15:0];
        default:  cfg_q <= cfg_q;
      endcase
    end
  end

  assign flush   = wr_pend_q && (ap_q == `A_CMD) && hwdata[`F_FLUSH];
  assign sw_trig = wr_pend_q && (ap_q == `A_CMD) && hwdata[`F_SWTRIG];

  // Trigger pin synchroniser plus edge flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tp_q    <= '0;
      above_q <= 1'b0;
    end
    else
    begin
      tp_q <= {tp_q[1:0], trig_pin};
      if (sample_valid)
        above_q <= above_now;
    end
  end

  assign above_now = sample_data > cfg_q.level;
  assign lvl_rise  = sample_valid && above_now && !above_q;
  assign ext_rise  = tp_q[1] && !tp_q[2];

  always_comb
  begin
    case (cfg_q.src)
      SRC_IMM: trig_ev = 1'b1;
      SRC_LVL: trig_ev = lvl_rise | sw_trig;
      SRC_EXT: trig_ev = ext_rise | sw_trig;
      default: trig_ev = sw_trig;
    endcase
  end

  // Sample weighting
  always_comb
  begin
    logic [21:0] ps;
    logic [21:0] ls;
    logic [16:0] p17;
    logic [16:0] l17;
    ps     = pos_q >> sh_q;
    ls     = cfg_q.integration_window_time >> sh_q;
    p17    = {9'd0, ps[7:0]};
    l17    = {9'd0, ls[7:0]};
    w_hann = p17 * (l17 - p17) + ((l17 * l17) >> 3);
  end

  assign use_hann = cfg_q.smooth && (st_q == ST_WIN);
  assign w        = use_hann ? w_hann : 17'd1;
  assign acc_en   = sample_valid && (st_q == ST_WIN || st_q == ST_BURST ||
                                     st_q == ST_GRACE || st_q == ST_SLOT);
  assign acc_add  = acc_en ? ({40'd0, sample_data} * {39'd0, w}) : 56'd0;
  assign ws_add   = acc_en ? {23'd0, w} : 40'd0;
  assign us_tick  = tus_q == 5'(`US_CYC - 1);
  assign win_need = cfg_q.fast ? `FAST_WINS : {cfg_q.avg, 1'b0};
  // At least, so fast mode switched on mid-run still ends on the next window
  assign win_last = (win_q + 18'd1) >= win_need;
  assign pos_end  = us_tick && ((pos_q + 22'd1) == cfg_q.integration_window_time);
  assign abort    = (st_q != ST_IDLE) &&
                    ((cfg_q.mode == MODE_CONT) != (st_q == ST_WIN || st_q == ST_GAP) ||
                     (cfg_q.mode == MODE_SLOT) != (st_q == ST_SLOT) ||
                     (cfg_q.mode == MODE_BURST) != (st_q == ST_BURST || st_q == ST_GRACE));

  // Measurement engine; every window edge falls on a microsecond tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q        <= ST_IDLE;
      tus_q       <= '0;
      pos_q       <= '0;
      win_q       <= '0;
      sidx_q      <= '0;
      gr_q        <= '0;
      plen_q      <= '0;
      pulse_len_q <= '0;
      acc_q       <= '0;
      ws_q        <= '0;
      sh_q        <= '0;
      chop_phase  <= 1'b0;
      meas_busy   <= 1'b0;
      dv_go_q     <= 1'b0;
      dv_num_q    <= '0;
      dv_den_q    <= '0;
      dv_tag_q    <= '0;
    end
    else
    begin
      dv_go_q   <= 1'b0;
      meas_busy <= st_q != ST_IDLE;
      tus_q     <= us_tick ? 5'd0 : tus_q + 5'd1;
      acc_q     <= acc_q + acc_add;
      ws_q      <= ws_q + ws_add;
      if (us_tick)
        pos_q <= pos_q + 22'd1;
      case (st_q)
        ST_IDLE:
        begin
          tus_q      <= '0;
          pos_q      <= '0;
          win_q      <= '0;
          acc_q      <= '0;
          ws_q       <= '0;
          chop_phase <= 1'b0;
          if (cfg_q.mode == MODE_BURST && lvl_rise)
          begin
            st_q   <= ST_BURST;
            plen_q <= '0;
            acc_q  <= {40'd0, sample_data};
            ws_q   <= 40'd1;
          end
          else if (cfg_q.mode == MODE_CONT && trig_ev)
          begin
            st_q <= ST_WIN;
            sh_q <= win_shift(cfg_q.integration_window_time);
          end
          else if (cfg_q.mode == MODE_SLOT && trig_ev)
          begin
            st_q   <= ST_SLOT;
            sidx_q <= '0;
          end
        end
        ST_WIN:
          if (pos_end)
          begin
            pos_q <= '0;
            if (win_last)
            begin
              dv_go_q  <= 1'b1;
              dv_num_q <= acc_q;
              dv_den_q <= ws_q;
              dv_tag_q <= '0;
              acc_q    <= '0;
              ws_q     <= '0;
              win_q    <= '0;
              st_q     <= cfg_q.fast ? ST_WIN : ST_IDLE;
            end
            else
            begin
              win_q      <= win_q + 18'd1;
              chop_phase <= ~chop_phase;
              st_q       <= ST_GAP;
            end
          end
        ST_GAP:
          if (us_tick && ((pos_q + 22'd1) == 22'(`CHOP_US)))
          begin
            pos_q <= '0;
            st_q  <= ST_WIN;
          end
        ST_BURST:
        begin
          if (us_tick)
            plen_q <= plen_q + 32'd1;
          if (sample_valid && !above_now)
          begin
            gr_q <= '0;
            st_q <= ST_GRACE;
          end
        end
        ST_GRACE:
        begin
          if (us_tick)
            plen_q <= plen_q + 32'd1;
          if (sample_valid && above_now)
            st_q <= ST_BURST;
          else if (cfg_q.grace == 19'd0 || (us_tick && (gr_q + 19'd1) >= cfg_q.grace))
          begin
            pulse_len_q <= plen_q;
            dv_go_q     <= 1'b1;
            dv_num_q    <= acc_q;
            dv_den_q    <= ws_q;
            dv_tag_q    <= '0;
            st_q        <= ST_IDLE;
          end
          else if (us_tick)
            gr_q <= gr_q + 19'd1;
        end
        ST_SLOT:
          if (us_tick && ((pos_q + 22'd1) == {5'd0, cfg_q.slen}))
          begin
            pos_q    <= '0;
            dv_go_q  <= 1'b1;
            dv_num_q <= acc_q;
            dv_den_q <= ws_q;
            dv_tag_q <= '{slot: 1'b1, idx: sidx_q[6:0]};
            acc_q    <= '0;
            ws_q     <= '0;
            sidx_q   <= sidx_q + 8'd1;
            if ((sidx_q + 8'd1) == cfg_q.qty)
              st_q <= ST_IDLE;
          end
        default: st_q <= ST_IDLE;
      endcase
      if (abort)
        st_q <= ST_IDLE;
    end
  end

  serial_divider u_div (
    .clk  (clk),
    .rst  (rst),
    .go   (dv_go_q),
    .num  (dv_num_q),
    .den  (dv_den_q),
    .done (dv_done),
    .quo  (dv_quo)
  );

  assign res_done = dv_done && !dv_tag_q.slot;

  // Results; a new result wins over a read that clears the flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_q   <= '0;
      res_vld_q  <= 1'b0;
      slot_vld_q <= 1'b0;
    end
    else
    begin
      if (res_done)
      begin
        result_q  <= dv_quo;
        res_vld_q <= 1'b1;
      end
      else if (rd_pend_q && ap_q == `A_RES)
        res_vld_q <= 1'b0;
      if (dv_done && dv_tag_q.slot && ({1'b0, dv_tag_q.idx} + 8'd1) == cfg_q.qty)
        slot_vld_q <= 1'b1;
      else if (st_q == ST_IDLE && cfg_q.mode == MODE_SLOT && trig_ev)
        slot_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (dv_done && dv_tag_q.slot)
      slot_res_q[dv_tag_q.idx] <= dv_quo;
    if (push)
      store_q[wp_q] <= dv_quo;
  end

  // Result store; flush discards even a result arriving in that cycle
  assign push = res_done && cfg_q.buf_en && (fill_q < cfg_q.depth) && !flush;
  assign pop  = rd_pend_q && (ap_q == `A_STORE) && (fill_q != 14'd0);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end
    else if (flush)
    begin
      wp_q   <= '0;
      rp_q   <= '0;
      fill_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 13'd1;
      if (pop)
        rp_q <= rp_q + 13'd1;
      fill_q <= fill_q + {13'd0, push} - {13'd0, pop};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gap_cyc_q <= '0;
    else
      gap_cyc_q <= (st_q == ST_GAP) ? gap_cyc_q + 12'd1 : 12'd0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence gap_exit_s;
    st_q == ST_GAP ##1 st_q == ST_WIN;
  endsequence

  sequence grace_end_s;
    st_q == ST_GRACE ##1 (st_q == ST_IDLE && cfg_q.mode == MODE_BURST);
  endsequence

  sequence slot_end_s;
    st_q == ST_SLOT ##1 (st_q == ST_IDLE && cfg_q.mode == MODE_SLOT);
  endsequence

  plain_weight_a: assert property (acc_en && !use_hann |-> w == 17'd1)
    else $error("unsmoothed sample weight not one");
  hann_weight_a: assert property (acc_en && use_hann |-> w >= 17'd8)
    else $error("smoothing weight below raised floor");
  chop_gap_a: assert property (gap_exit_s |-> $past(gap_cyc_q) == 12'(`CHOP_CYC) - 12'd1)
    else $error("chopper switch gap has wrong length");
  win_count_a: assert property (dv_go_q && !dv_tag_q.slot && cfg_q.mode == MODE_CONT
                                |-> $past(win_last))
    else $error("result launched before all windows done");
  fast_b2b_a: assert property (st_q == ST_WIN && cfg_q.fast && pos_end && !abort
                               |=> st_q == ST_WIN && pos_q == '0 && dv_go_q)
    else $error("fast mode left a gap between windows");
  flush_empty_a: assert property (flush |=> fill_q == '0)
    else $error("store not empty after flush");
  fill_read_a: assert property (rd_pend_q && ap_q == `A_FILL
                                |=> hreadyout && hrdata == {18'd0, $past(fill_q)})
    else $error("fill read returned wrong count");
  depth_bound_a: assert property (fill_q > $past(fill_q)
                                  |-> fill_q <= $past(cfg_q.depth))
    else $error("store fill beyond depth");
  burst_start_a: assert property (st_q == ST_IDLE && cfg_q.mode == MODE_BURST && lvl_rise
                                  |=> st_q == ST_BURST)
    else $error("burst not started at level crossing");
  grace_end_a: assert property (grace_end_s |-> cfg_q.grace == '0 ||
                                ($past(gr_q) + 19'd1) >= cfg_q.grace)
    else $error("burst ended before grace time");
  slot_count_a: assert property (slot_end_s |-> ($past(sidx_q) + 8'd1) == cfg_q.qty)
    else $error("slot sweep ended at wrong count");
  res_hold_a: assert property (res_vld_q && !res_done |=> result_q == $past(result_q))
    else $error("valid result changed without a new one");

endmodule

// [src/serial_divider.sv]
`timescale 1ns/100ps
module serial_divider
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [55:0] num,
  input  wire logic [39:0] den,
  output logic             done,
  output logic [31:0]      quo
);
  logic [55:0] q_q;
  logic [40:0] rem_q;
  logic [39:0] d_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic [40:0] sh;

  assign sh  = {rem_q[39:0], q_q[55]};
  assign quo = q_q[31:0];

  // Restoring division, one quotient bit per cycle; zero divisor gives all ones
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_q    <= '0;
      rem_q  <= '0;
      d_q    <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (go)
      begin
        q_q    <= num;
        rem_q  <= '0;
        d_q    <= den;
        cnt_q  <= 6'd56;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (sh >= {1'b0, d_q})
        begin
          rem_q <= sh - {1'b0, d_q};
          q_q   <= {q_q[54:0], 1'b1};
        end
        else
        begin
          rem_q <= sh;
          q_q   <= {q_q[54:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'd1;
        if (cnt_q == 6'd1)
        begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "meas_params.svh"
module testbench;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        sample_valid;
  logic        trig_pin;
  logic        chop_phase;
  logic        meas_busy;
  logic        last;
  logic [1:0]  htrans;
  logic [15:0] v;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  integer      seed = 32'hd3ed;
  integer      num_errors = 0;
  integer      tests_run = 0;
  integer      cyc = 0;
  integer      n;
  integer      k;
  integer      flips;
  int          q[$];
  // Rows 0..6 are read only, the rest write then read back
  logic [11:0] ta [22] = '{`A_CTRL, `A_INTEGRATION_WINDOW_TIME, `A_AVG, `A_GRACE, `A_SLEN, `A_SQTY, `A_DEPTH,
    `A_CTRL, `A_INTEGRATION_WINDOW_TIME, `A_INTEGRATION_WINDOW_TIME, `A_SQTY, `A_DEPTH, `A_DEPTH, `A_SLEN, `A_GRACE, 12'h100,
    `A_AVG, `A_AVG, `A_INTEGRATION_WINDOW_TIME, `A_SQTY, `A_DEPTH, `A_GRACE};
  logic [31:0] tw [22] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h3, 32'h0, 32'h2dc6c0, 32'hc8, 32'h2328, 32'h0, 32'h5, 32'h61a80, 32'h5,
    32'h0, 32'h2, 32'h8, 32'h2, 32'h2, 32'h2};
  logic [31:0] te [22] = '{32'h0, 32'h4e20, 32'h4, 32'h1, 32'h3e8, 32'h8, 32'h1,
    32'h3, 32'h8, 32'h1e8480, 32'h80, 32'h2000, 32'h1, 32'ha, 32'h493e0, 32'h0,
    32'h1, 32'h2, 32'h8, 32'h2, 32'h2, 32'h2};

  power_meter dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .sample_valid(sample_valid),
    .sample_data(v), .trig_pin(trig_pin), .chop_phase(chop_phase), .meas_busy(meas_busy));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Random gaps in the sample stream
  always @(posedge clk)
    sample_valid <= 1'($random(seed));

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; read data lands in r
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Software trigger, then time the busy span and count chopper flips
  task automatic run_trig();
    xfer(1'b1, `A_CMD, 32'h2);
    for (n = 0; n < 50 && meas_busy !== 1'b1; n++) @(posedge clk);
    flips = 0;
    last = chop_phase;
    for (n = 0; n < 9000 && meas_busy === 1'b1; n++)
    begin
      @(posedge clk);
      flips += (chop_phase !== last);
      last = chop_phase;
    end
  endtask

  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    sample_valid = 1'b0;
    trig_pin = 1'b0;
    v = 16'($random(seed));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 22; k++)
    begin
      if (k >= 7)
        xfer(1'b1, ta[k], tw[k]);
      xfer(1'b0, ta[k], 32'h0);
      chk(r, te[k]);
    end
    $display("test done: reset values and ranges");
    // Count of 2 must be ignored in fast mode
    xfer(1'b1, `A_CTRL, 32'h08);
    repeat (5) @(posedge clk);
    n = 0;
    repeat (600)
    begin
      @(posedge clk);
      n += (chop_phase !== 1'b0 || meas_busy !== 1'b1);
    end
    chk(n, 0);
    xfer(1'b0, `A_RES, 32'h0);
    chk(r, {16'h0, v});
    xfer(1'b1, `A_CMD, 32'h1);
    xfer(1'b1, `A_CTRL, 32'h18);
    repeat (1000) @(posedge clk);
    xfer(1'b1, `A_CTRL, 32'h3);
    repeat (6) if (q.size() < 2) q.push_back(v);
    xfer(1'b0, `A_FILL, 32'h0);
    chk(r, 32'(q.size()));
    while (q.size() > 0)
    begin
      xfer(1'b0, `A_STORE, 32'h0);
      chk(r, 32'(q.pop_front()));
    end
    xfer(1'b1, `A_CTRL, 32'h18);
    repeat (500) @(posedge clk);
    xfer(1'b1, `A_CTRL, 32'h3);
    xfer(1'b1, `A_CMD, 32'h1);
    xfer(1'b0, `A_FILL, 32'h0);
    chk(r, 32'h0);
    $display("test done: fast mode and store");
    xfer(1'b1, `A_CTRL, 32'h60);
    run_trig();
    chk(32'(n >= 6640 && n <= 6720), 32'h1);
    chk(flips, 4);
    v <= 16'($random(seed));
    xfer(1'b1, `A_CTRL, 32'h64);
    run_trig();
    // Divider needs about 58 cycles after the last window
    repeat (100) @(posedge clk);
    xfer(1'b0, `A_RES, 32'h0);
    chk(r, {16'h0, v});
    $display("test done: chopped and smoothed");
    v <= 16'h0;
    xfer(1'b1, `A_CTRL, 32'h01);
    repeat (100) @(posedge clk);
    xfer(1'b0, `A_STAT, 32'h0);
    chk(r[6:4], 3'h0);
    v <= 16'h0200;
    repeat (200) @(posedge clk);
    v <= 16'h0;
    repeat (200) @(posedge clk);
    xfer(1'b0, `A_PLEN, 32'h0);
    chk(32'(r >= 11 && r <= 13), 32'h1);
    $display("test done: burst");
    v <= 16'($random(seed));
    xfer(1'b1, `A_CTRL, 32'h3);
    xfer(1'b1, `A_CTRL, 32'h42);
    repeat (100) @(posedge clk);
    xfer(1'b0, `A_STAT, 32'h0);
    chk(r[1], 1'b0);
    chk(r[6:4], 3'h0);
    trig_pin <= 1'b1;
    repeat (3) @(posedge clk);
    trig_pin <= 1'b0;
    for (k = 0; k < 300 && r[1] !== 1'b1; k++) xfer(1'b0, `A_STAT, 32'h0);
    for (k = 0; k < 2; k++)
    begin
      xfer(1'b0, 12'h200 + 12'(k * 4), 32'h0);
      chk(r, {16'h0, v});
    end
    $display("test done: timeslots");
    conclude();
  end
endmodule
